// [verilog/uhtc_consts.svh]
// Constants for the host transaction control block
`ifndef UHTC_CONSTS_SVH
`define UHTC_CONSTS_SVH
`define UHTC_CTRL_OFS      12'h000
`define UHTC_STAT_OFS      12'h004
`define UHTC_CTRL_RESET    16'h0000
`define UHTC_CTRL_WMASK    16'h00F1
`define UHTC_BIT_PREAMBLE  7
`define UHTC_BIT_TOGGLE    6
`define UHTC_BIT_ALIGN     5
`define UHTC_BIT_ISO       4
`define UHTC_BIT_LAUNCH    0
`define UHTC_ADDR_W        12
`endif

// [verilog/uhtc_pkg.sv]
// Types for the host transaction control block
package uhtc_pkg;
	// Options handed to the packet engine with each launch
	typedef struct packed {
		logic preamble;
		logic data1;
		logic align;
		logic iso;
	} uhtc_opts_t;
	// Launch sequencer states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_WAIT  = 3'b010,
		ST_BUSY  = 3'b100
	} uhtc_state_t;
endpackage

// [verilog/uhtc_launch.sv]
// Launch sequencer: waits for idle engine, and for frame marker if aligned, then starts
`timescale 1ns/100ps
`default_nettype none
module uhtc_launch (
	input  wire logic               clk,      // System clock
	input  wire logic               rst_n,    // Async reset, active low
	input  wire logic               arm,      // Launch bit held high
	input  wire logic               align,    // Wait for frame marker
	input  wire logic               marker,   // SOF/EOP sent pulse
	input  wire logic               eng_idle, // Packet engine free
	input  wire logic               done,     // Transaction done pulse
	output logic                    start,    // Start pulse to engine
	output logic                    finish,   // Clears the launch bit
	output uhtc_pkg::uhtc_state_t   state     // Current state
);
	import uhtc_pkg::*;
	uhtc_state_t state_q, state_d;
	// Next state; with alignment the engine must also be free in the marker cycle
	always_comb begin
		state_d = state_q;
		start   = 1'b0;
		finish  = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (arm) begin
					state_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (!arm) begin
					state_d = ST_IDLE;
				end else if (eng_idle && (!align || marker)) begin // see (RULE_06)
					start   = 1'b1;
					state_d = ST_BUSY;
				end
			end
			ST_BUSY: begin
				if (done) begin
					finish  = 1'b1; // see (RULE_09)
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end
	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end
	assign state = state_q;

	// ****************************************
	// Assertions
	// ****************************************
	align_wait_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RULE_05)
		start && align |-> marker)
		else $error("aligned start without frame marker");
	idle_start_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RULE_06)
		(state_q == ST_WAIT) && arm && eng_idle && !align |-> start)
		else $error("unaligned start delayed");
	busy_done_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RULE_09)
		(state_q == ST_BUSY) && done |=> (state_q == ST_IDLE))
		else $error("no return to idle after done");
	start_cov_c: cover property (@(posedge clk) disable iff (!rst_n)
		start && align);
	finish_cov_c: cover property (@(posedge clk) disable iff (!rst_n)
		finish);
endmodule
`default_nettype wire

// [verilog/uhtc_top.sv]
// Host transaction control register with AXI4-Lite slave
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "uhtc_consts.svh"
// Function
// (RULE_01) Preamble enable bit 7 sends a preamble before every low-speed packet.
// (RULE_02) Software sets the preamble bit only for low-speed peripherals.
// (RULE_03) Toggle select bit 6 picks DATA1 when set and DATA0 when clear.
// (RULE_04) Toggle select never affects reception; no toggle check on receive.
// (RULE_05) Frame alignment bit 5 aligns to SOF at full speed, EOP at low speed.
// (RULE_06) Aligned packets wait for the marker, else start once engine idle.
// (RULE_07) Isochronous bit 4 selects isochronous or ordinary transactions.
// (RULE_08) Bits 7..4 and 0 are writable, others reserved, all reset to zero.
// (RULE_09) Writing 1 to launch bit 0 starts a transaction; hardware clears it.
// (RULE_10) Reserved bits ignore writes and read as zero.
module uhtc_top (
	input  wire logic              CLK,          // System clock 100 MHz
	input  wire logic              RST_N,        // Async reset, active low
	input  wire logic [11:0]       AWADDR,       // Write address
	input  wire logic              AWVALID,      // Write address valid
	output logic                   AWREADY,      // Write address ready
	input  wire logic [31:0]       WDATA,        // Write data
	input  wire logic [3:0]        WSTRB,        // Write strobes
	input  wire logic              WVALID,       // Write data valid
	output logic                   WREADY,       // Write data ready
	output logic [1:0]             BRESP,        // Write response
	output logic                   BVALID,       // Write response valid
	input  wire logic              BREADY,       // Write response ready
	input  wire logic [11:0]       ARADDR,       // Read address
	input  wire logic              ARVALID,      // Read address valid
	output logic                   ARREADY,      // Read address ready
	output logic [31:0]            RDATA,        // Read data
	output logic [1:0]             RRESP,        // Read response
	output logic                   RVALID,       // Read data valid
	input  wire logic              RREADY,       // Read data ready
	input  wire logic              FULL_SPEED,   // Port runs at full speed
	input  wire logic              SOF_SENT,     // SOF transmitted pulse
	input  wire logic              EOP_SENT,     // Low-speed EOP sent pulse
	input  wire logic              ENG_IDLE,     // Packet engine free
	input  wire logic              XFER_DONE,    // Transaction done pulse
	output logic                   XFER_START,   // Start pulse to engine
	output uhtc_pkg::uhtc_opts_t   XFER_OPTS     // Options for the transfer
);
	import uhtc_pkg::*;

	// ****************************************
	// Control register and launch
	// ****************************************
	logic [15:0] ctrl_q, ctrl_d;
	logic        marker, finish, wr_fire, wr_ctrl;
	uhtc_state_t st;
	logic        aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
	logic [11:0] awa_q, awa_d, ara;
	logic [31:0] wd_q, wd_d, rd_q, rd_d;
	logic [3:0]  ws_q, ws_d;
	logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
	logic        wr_mapped;

	// Marker depends on link speed: SOF at full speed, EOP at low speed
	assign marker = FULL_SPEED ? SOF_SENT : EOP_SENT; // see (RULE_05)

	uhtc_launch u_launch (
		.clk      (CLK),
		.rst_n    (RST_N),
		.arm      (ctrl_q[`UHTC_BIT_LAUNCH]),
		.align    (ctrl_q[`UHTC_BIT_ALIGN]),
		.marker   (marker),
		.eng_idle (ENG_IDLE),
		.done     (XFER_DONE),
		.start    (XFER_START),
		.finish   (finish),
		.state    (st)
	);

	// Options follow the register; the toggle goes only to transmit and
	// nothing on the receive side feeds back into it, see (RULE_04)
	always_comb begin
		XFER_OPTS.preamble = ctrl_q[`UHTC_BIT_PREAMBLE]; // see (RULE_01)
		XFER_OPTS.data1    = ctrl_q[`UHTC_BIT_TOGGLE];   // see (RULE_03)
		XFER_OPTS.align    = ctrl_q[`UHTC_BIT_ALIGN];
		XFER_OPTS.iso      = ctrl_q[`UHTC_BIT_ISO];      // see (RULE_07)
	end

	// Write fires when both address and data are held
	assign wr_fire = aw_q && w_q && !b_q;
	assign wr_ctrl = wr_fire && (awa_q == `UHTC_CTRL_OFS) && ws_q[0];
	// Only the two decoded words answer OKAY
	assign wr_mapped = (awa_q == `UHTC_CTRL_OFS) || (awa_q == `UHTC_STAT_OFS);

	// Software write masked to writable bits; hardware clear loses to a
	// write of 1 in the same cycle so a relaunch is not lost
	always_comb begin
		ctrl_d = ctrl_q;
		if (finish) begin
			ctrl_d[`UHTC_BIT_LAUNCH] = 1'b0; // see (RULE_09)
		end
		if (wr_ctrl) begin
			ctrl_d = wd_q[15:0] & `UHTC_CTRL_WMASK; // see (RULE_08) (RULE_10)
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_q <= `UHTC_CTRL_RESET; // see (RULE_08)
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// ****************************************
	// AXI4-Lite write channel
	// ****************************************
	always_comb begin
		aw_d    = aw_q;
		w_d     = w_q;
		b_d     = b_q;
		awa_d   = awa_q;
		wd_d    = wd_q;
		ws_d    = ws_q;
		bresp_d = bresp_q;
		if (AWVALID && AWREADY) begin
			aw_d  = 1'b1;
			awa_d = AWADDR;
		end
		if (WVALID && WREADY) begin
			w_d  = 1'b1;
			wd_d = WDATA;
			ws_d = WSTRB;
		end
		if (wr_fire) begin
			aw_d    = 1'b0;
			w_d     = 1'b0;
			b_d     = 1'b1;
			bresp_d = wr_mapped ? 2'h0 : 2'h2; // Unmapped gives SLVERR
		end
		if (b_q && BREADY) begin
			b_d = 1'b0;
		end
	end
	assign AWREADY = !aw_q && !b_q;
	assign WREADY  = !w_q && !b_q;
	assign BVALID  = b_q;
	assign BRESP   = bresp_q;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			aw_q    <= 1'b0;
			w_q     <= 1'b0;
			b_q     <= 1'b0;
			awa_q   <= 12'h000;
			wd_q    <= 32'h00000000;
			ws_q    <= 4'h0;
			bresp_q <= 2'h0;
		end else begin
			aw_q    <= aw_d;
			w_q     <= w_d;
			b_q     <= b_d;
			awa_q   <= awa_d;
			wd_q    <= wd_d;
			ws_q    <= ws_d;
			bresp_q <= bresp_d;
		end
	end

	// ****************************************
	// AXI4-Lite read channel
	// ****************************************
	assign ara = ARADDR;
	always_comb begin
		r_d     = r_q;
		rd_d    = rd_q;
		rresp_d = rresp_q;
		if (ARVALID && ARREADY) begin
			r_d = 1'b1;
			if (ara == `UHTC_CTRL_OFS) begin
				rd_d    = {16'h0000, ctrl_q}; // see (RULE_10)
				rresp_d = 2'h0;
			end else if (ara == `UHTC_STAT_OFS) begin
				rd_d    = {29'h00000000, st};
				rresp_d = 2'h0;
			end else begin
				rd_d    = 32'h00000000;
				rresp_d = 2'h2;
			end
		end else if (r_q && RREADY) begin
			r_d = 1'b0;
		end
	end
	assign ARREADY = !r_q;
	assign RVALID  = r_q;
	assign RDATA   = rd_q;
	assign RRESP   = rresp_q;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			r_q     <= 1'b0;
			rd_q    <= 32'h00000000;
			rresp_q <= 2'h0;
		end else begin
			r_q     <= r_d;
			rd_q    <= rd_d;
			rresp_q <= rresp_d;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	resv_zero_a: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE_10)
		ctrl_q[15:8] == 8'h00 && ctrl_q[3:1] == 3'h0)
		else $error("reserved control bits set");
	preamble_out_a: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE_01)
		wr_ctrl |=> XFER_OPTS.preamble == $past(wd_q[7]))
		else $error("preamble option mismatch");
	toggle_out_a: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE_03)
		wr_ctrl |=> XFER_OPTS.data1 == $past(wd_q[6]))
		else $error("toggle option mismatch");
	iso_out_a: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE_07)
		wr_ctrl |=> XFER_OPTS.iso == $past(wd_q[4]))
		else $error("iso option mismatch");
	ctrl_write_a: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE_08)
		wr_ctrl |=> ctrl_q[7:4] == $past(wd_q[7:4]))
		else $error("control write lost");
	launch_clear_a: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE_09)
		finish && !wr_ctrl |=> !ctrl_q[0])
		else $error("launch bit not cleared");
	no_rx_check_a: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE_04)
		!wr_ctrl |=> $stable(ctrl_q[7:4]))
		else $error("option bits changed without a write");
	bresp_cov_c: cover property (@(posedge CLK) disable iff (!RST_N)
		BVALID && BREADY);
	iso_cov_c: cover property (@(posedge CLK) disable iff (!RST_N)
		XFER_START && XFER_OPTS.iso);
endmodule
`default_nettype wire

// [dv/uhtc_engine_model.sv]
// Behavioural packet engine and peripheral seen by the control block
`timescale 1ns/100ps
`default_nettype none
module uhtc_engine_model #(
	parameter int FRAME = 30                // Cycles between frame markers
) (
	input  wire logic clk,                  // System clock
	input  wire logic rst_n,                // Async reset, active low
	input  wire logic full_speed,           // Port speed select
	input  wire logic slow,                 // Stretch each transaction
	input  wire logic start,                // Start pulse from the block
	output logic      eng_idle,             // Engine free
	output logic      sof_sent,             // SOF transmitted pulse
	output logic      eop_sent,             // EOP transmitted pulse
	output logic      done                  // Transaction done pulse
);
	int frm_q;
	int busy_q;
	// Markers run free so an aligned launch may wait most of a frame
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frm_q <= 0;
			busy_q <= 0;
			sof_sent <= 1'b0;
			eop_sent <= 1'b0;
			done <= 1'b0;
		end else begin
			frm_q <= (frm_q == FRAME - 1) ? 0 : frm_q + 1;
			sof_sent <= full_speed && (frm_q == FRAME - 1);
			eop_sent <= !full_speed && (frm_q == FRAME - 1);
			done <= (busy_q == 1);
			if (start)
				busy_q <= slow ? 12 : 2;
			else if (busy_q != 0)
				busy_q <= busy_q - 1;
		end
	end
	// Not idle while busy or while reporting completion
	assign eng_idle = (busy_q == 0) && !done;
endmodule
`default_nettype wire

// [dv/usb_host_transaction_control_bench.sv]
// Self-checking bench for the host transaction control block
`timescale 1ns/100ps
`default_nettype none
`include "uhtc_consts.svh"
module usb_host_transaction_control_bench;
	import uhtc_pkg::*;
	logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, fs, slow;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic awready, wready, bvalid, arready, rvalid, sof, eop, idle, done, start;
	logic [1:0] bresp, rresp;
	logic [31:0] d;
	logic [1:0] r;
	uhtc_opts_t opts;
	int failures = 0, samples_checked = 0, starts = 0, lat;
	logic mark;
	uhtc_top dut_u (.CLK(clk), .RST_N(rst_n), .AWADDR(awaddr),
		.AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
		.WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
		.BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
		.ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
		.RREADY(rready), .FULL_SPEED(fs), .SOF_SENT(sof), .EOP_SENT(eop),
		.ENG_IDLE(idle), .XFER_DONE(done), .XFER_START(start),
		.XFER_OPTS(opts));
	uhtc_engine_model eng_u (.clk(clk), .rst_n(rst_n), .full_speed(fs),
		.slow(slow), .start(start), .eng_idle(idle), .sof_sent(sof),
		.eop_sent(eop), .done(done));
	// Clock, 10 ns period
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Note the marker seen at each start pulse
	always @(posedge clk) begin
		if (start === 1'b1) begin
			starts++;
			mark = fs ? sof : eop;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		if (failures == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Address and data offered together, each released once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		bit ah, wh;
		ah = 1;
		wh = 1;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (ah || wh) begin
			@(posedge clk);
			if (ah && awready === 1'b1) begin
				awvalid <= 1'b0;
				ah = 0;
			end
			if (wh && wready === 1'b1) begin
				wvalid <= 1'b0;
				wh = 0;
			end
		end
		while (bvalid !== 1'b1) @(posedge clk);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge clk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	// Arm a transfer, count cycles to start, then let it finish
	task automatic launch(input logic [7:0] v);
		int n;
		n = starts;
		lat = 0;
		wr(`UHTC_CTRL_OFS, {24'h000000, v});
		while (starts == n) begin
			@(posedge clk);
			lat++;
		end
		rd(`UHTC_STAT_OFS);
		chk(d, 32'h00000004);
		repeat (20) @(posedge clk);
		rd(`UHTC_CTRL_OFS);
		chk(d, {24'h000000, v[7:1], 1'b0});
	endtask
	initial begin
		#200000;
		failures++;
		report_and_stop();
	end
	// Main sequence
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, slow} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		fs = 1'b1;
		rst_n = 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(`UHTC_CTRL_OFS);
		chk(d, 32'h00000000);
		chk(32'(r), 32'h00000000);
		rd(`UHTC_STAT_OFS);
		chk(d, 32'h00000001);
		// One option bit at a time reaches the engine
		for (int b = 4; b < 8; b++) begin
			wr(`UHTC_CTRL_OFS, 32'h1 << b);
			chk(32'(r), 32'h00000000);
			chk(32'(opts), 32'h1 << (b - 4));
			rd(`UHTC_CTRL_OFS);
			chk(d, 32'h1 << b);
		end
		wr(`UHTC_CTRL_OFS, 32'hFFFFFFFE);
		rd(`UHTC_CTRL_OFS);
		chk(d, 32'h000000F0);
		wr(12'h008, 32'h00000001);
		chk(32'(r), 32'h00000002);
		rd(12'h008);
		chk({d[29:0], r}, 32'h00000002);
		launch(8'h41);
		chk(32'(lat < 8), 32'h00000001);
		chk(32'(opts), 32'h00000004);
		slow <= 1'b1;
		launch(8'h21);
		chk(32'(mark), 32'h00000001);
		fs <= 1'b0;
		slow <= 1'b0;
		launch(8'h21);
		chk(32'(mark), 32'h00000001);
		wr(`UHTC_CTRL_OFS, 32'h00000080);
		chk(32'(opts), 32'h00000008);
		chk(32'(starts), 32'h00000003);
		report_and_stop();
	end
endmodule
`default_nettype wire
